// ===== omc_top.sv
// Purpose: operating mode controller with scan cycle and status word
// Assumes: fault inputs come from same-clock logic, pins are async
// Notes:   error and bootloader modes are left only by reset
//
// Summary of operation
// - power-up samples switch, then runs self-test
// - usb-only power keeps i/o disabled
// - program starts only if main power, loaded
// - cycle start, sample, execute, write, repeat
// - program reads only the input snapshot
// - i/o, interface, rtc, firmware, os, filesystem, version, retain faults and slow cycles enter error mode
// - status word readable at 0xf0b4
// - bits 0-3 flag i/o failures
// - bits 4,6,8,9 flag interface failures, bit 11 rtc failure
// - bit 12 while main power absent
// - bit 13 firmware fault or slow cycle
// - bits 15-17 os, filesystem, formatted
// - bit 19 version fault, bit 18 parameters
// - bit 20 factory reset, bit 23 none
// - bit 22 shows switch at halt
// - bit 24 when program was terminated
// - bit 31 retained program faulty
// - halt stops program, enters direct i/o
// - direct i/o denies network variables
// - bootloader allows only usb firmware update
// - bootloader on firmware start failure during the scan cycle
// - button held at power-up forces bootloader
`timescale 1ns/1ps
`default_nettype none
module omc_top #(
  parameter int CYC_LIMIT_CYCLES = omc_pkg::CYC_LIMIT, // 100 ms
  parameter bit HAS_AO           = 1'b1 // analog outputs fitted
) (
  // clock and reset
  input  wire logic                     MCLK,
  input  wire logic                     RSTN,
  // operator and power pins
  input  wire logic                     RUN_HALT_PIN,
  input  wire logic                     SVC_BTN_PIN,
  input  wire logic                     MAIN_PWR_PIN,
  input  wire logic [omc_pkg::IN_W-1:0] IN_PINS,
  // self-test handshake
  output logic                          TEST_GO,
  input  wire logic                     TEST_DONE,
  input  wire logic                     TEST_FAIL,
  // program engine
  input  wire logic                     PROG_LOADED,
  output logic                          EXEC_GO,
  input  wire logic                     EXEC_DONE,
  output logic      [omc_pkg::IN_W-1:0] IN_SNAP,
  output logic                          OUT_UPDATE,
  // fault sources
  input  wire logic [3:0]               FLT_IO,
  input  wire logic [3:0]               FLT_IF,
  input  wire logic                     FLT_RTC,
  input  wire logic                     FLT_FW,
  input  wire logic                     FLT_OS,
  input  wire logic                     FLT_FS,
  input  wire logic                     STOR_FMT,
  input  wire logic                     NO_PARAMS,
  input  wire logic                     FW_MISMATCH,
  input  wire logic                     FACTORY_RST,
  input  wire logic                     ARCH_FLT,
  input  wire logic                     RETAIN_BAD,
  input  wire logic                     FW_START_FAIL,
  // mode outputs
  output logic                          MODE_OPER,
  output logic                          MODE_ERR,
  output logic                          MODE_DIO,
  output logic                          MODE_BOOT,
  output logic                          IO_EN,
  output logic                          NETVAR_EN,
  output logic                          USB_PROG_EN,
  output logic                          FWUPD_EN,
  // status word read port
  input  wire logic                     ST_RD,
  input  wire logic [15:0]              ST_ADDR,
  output logic                          ST_ACK,
  output logic                          ST_NAK,
  output logic      [31:0]              ST_DATA
);
  import omc_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    omc_state_t       st;    // mode / cycle step
    logic [1:0]       wait_c; // settle counter
    logic             halt;  // switch latched at power-up
    logic             boot;  // button latched at power-up
    logic [IN_W-1:0]  snap;  // input snapshot
    logic [31:0]      stat;  // status word
    logic             term;  // program was terminated
    logic             ovr;   // slow cycle seen
    logic             ack;   // read answered
    logic             nak;   // read refused
    logic [31:0]      rdata; // read data
    logic             t_go;  // self-test start pulse
    logic             x_go;  // execute pulse
    logic             o_upd; // output update pulse
  } omc_regs_t;
  localparam omc_regs_t RST = '{st: ST_INIT, default: '0};
  omc_regs_t r, nxt;
  // synchronised pins
  logic              halt_s;  // switch at halt
  logic              btn_s;   // service button held
  logic              main_s;  // main supply present
  logic [IN_W-1:0]   in_s;    // live inputs
  logic [31:0]       word;    // status word being built
  logic              err_any; // any error condition
  logic              running; // inside the scan cycle
  omc_wdog_if        wd ();
  // ---------------------------------------------------------------
  // pin synchronisers and cycle timer
  // ---------------------------------------------------------------
  omc_sync #(.W(IN_W + 3)) u_sync (
    .clk   (MCLK),
    .rst_n (RSTN),
    .d     ({RUN_HALT_PIN, SVC_BTN_PIN, MAIN_PWR_PIN, IN_PINS}),
    .q     ({halt_s, btn_s, main_s, in_s})
  );
  omc_wdog #(.LIMIT(CYC_LIMIT_CYCLES)) u_wdog (
    .clk   (MCLK),
    .rst_n (RSTN),
    .wd    (wd)
  );
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // true in the four steps of the scan cycle
  function automatic logic in_cycle(input omc_state_t s);
    return s inside {ST_CSTART, ST_SAMPLE, ST_EXEC, ST_WRITE};
  endfunction
  assign running    = in_cycle(r.st);
  assign wd.run     = running;
  assign wd.restart = (nxt.st == ST_CSTART) && (r.st != ST_CSTART);
  // ---------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------
  always_comb begin
    word             = '0; // unassigned bits stay zero
    word[B_DI]       = FLT_IO[0];
    word[B_DO]       = FLT_IO[1];
    word[B_AI]       = FLT_IO[2];
    word[B_AO]       = FLT_IO[3] & HAS_AO;
    word[B_ETH]      = FLT_IF[0];
    word[B_USB]      = FLT_IF[1];
    word[B_RS1]      = FLT_IF[2];
    word[B_RS2]      = FLT_IF[3];
    word[B_RTC]      = FLT_RTC;
    word[B_NOPWR]    = !main_s;
    word[B_FWCYC]    = FLT_FW | r.ovr;
    word[B_OS]       = FLT_OS;
    word[B_FS]       = FLT_FS;
    word[B_FMT]      = STOR_FMT;
    word[B_NOPAR]    = NO_PARAMS;
    word[B_FWVER]    = FLT_FW | FW_MISMATCH;
    word[B_FACT]     = FACTORY_RST & !PROG_LOADED;
    word[B_ARCH]     = ARCH_FLT;
    word[B_HALT]     = halt_s;
    word[B_NOPROG]   = !PROG_LOADED;
    word[B_TERM]     = r.term;
    word[B_RETAIN]   = RETAIN_BAD;
  end
  // faults that force error mode
  assign err_any = |word[B_ETH:B_DI] | word[B_USB] | word[B_RS1]
                 | word[B_RS2] | word[B_RTC] | word[B_FWCYC]
                 | |word[B_FS:B_OS] | word[B_FWVER] | word[B_RETAIN];
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt       = r;
    nxt.t_go  = 1'b0;
    nxt.x_go  = 1'b0;
    nxt.o_upd = 1'b0;
    nxt.ack   = 1'b0;
    nxt.nak   = 1'b0;
    nxt.stat  = word;
    // slow cycle is sticky, only reset clears it
    if (wd.overrun) begin
      nxt.ovr = 1'b1;
    end
    // status read port
    if (ST_RD) begin
      if (ST_ADDR == STAT_ADDR) begin
        nxt.ack   = 1'b1;
        nxt.rdata = r.stat;
      end else begin
        nxt.nak = 1'b1;
      end
    end
    unique case (r.st)
      ST_INIT: begin
        // let synchronisers settle, then latch pins
        if (r.wait_c == SETTLE) begin
          nxt.halt = halt_s;
          nxt.boot = btn_s;
          nxt.st   = ST_TEST;
          nxt.t_go = 1'b1;
        end else begin
          nxt.wait_c = r.wait_c + 1'b1;
        end
      end
      ST_TEST: begin
        if (TEST_DONE) begin
          if (r.boot) begin
            nxt.st = ST_BOOT;
          end else if (TEST_FAIL || err_any) begin
            nxt.st = ST_ERR;
          end else if (!main_s || !PROG_LOADED) begin
            nxt.st = ST_IDLE;
          end else if (r.halt) begin
            nxt.st = ST_DIO;
          end else begin
            nxt.st = ST_CSTART;
          end
        end
      end
      ST_IDLE: begin
        if (err_any) begin
          nxt.st = ST_ERR;
        end else if (main_s && halt_s) begin
          nxt.st = ST_DIO;
        end else if (main_s && PROG_LOADED) begin
          nxt.st   = ST_CSTART;
          nxt.term = 1'b0; // stale stop flag must not reach cycle start
        end
      end
      ST_DIO: begin
        if (err_any) begin
          nxt.st = ST_ERR;
        end else if (!main_s) begin
          nxt.st = ST_IDLE;
        end else if (!halt_s && PROG_LOADED) begin
          nxt.st   = ST_CSTART;
          nxt.term = 1'b0; // resumed program clears the stop flag
        end
      end
      ST_CSTART, ST_SAMPLE, ST_EXEC, ST_WRITE: begin
        if (FW_START_FAIL) begin
          nxt.st = ST_BOOT;
        end else if (err_any) begin
          nxt.st = ST_ERR;
        end else if (!main_s) begin
          nxt.st = ST_IDLE;
        end else if (halt_s) begin
          nxt.st   = ST_DIO;
          nxt.term = 1'b1;
        end else begin
          unique case (r.st)
            ST_CSTART: begin
              nxt.st   = ST_SAMPLE;
              nxt.term = 1'b0;
            end
            ST_SAMPLE: begin
              nxt.snap = in_s;
              nxt.st   = ST_EXEC;
              nxt.x_go = 1'b1;
            end
            ST_EXEC: begin
              if (EXEC_DONE) begin
                nxt.st    = ST_WRITE;
                nxt.o_upd = 1'b1;
              end
            end
            default: begin
              nxt.st = ST_CSTART;
            end
          endcase
        end
      end
      ST_ERR: begin
        nxt.st = ST_ERR;
      end
      ST_BOOT: begin
        nxt.st = ST_BOOT;
      end
      default: begin
        nxt.st = ST_ERR;
      end
    endcase
  end
  // register with synchronous reset
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      r <= RST;
    end else begin
      r <= nxt;
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign TEST_GO     = r.t_go;
  assign EXEC_GO     = r.x_go;
  assign OUT_UPDATE  = r.o_upd;
  assign IN_SNAP     = r.snap;
  assign ST_ACK      = r.ack;
  assign ST_NAK      = r.nak;
  assign ST_DATA     = r.rdata;
  assign MODE_OPER   = running;
  assign MODE_ERR    = (r.st == ST_ERR);
  assign MODE_DIO    = (r.st == ST_DIO);
  assign MODE_BOOT   = (r.st == ST_BOOT);
  assign IO_EN       = main_s && (running || MODE_DIO);
  assign NETVAR_EN   = main_s && running;
  assign USB_PROG_EN = r.st inside {ST_IDLE, ST_DIO, ST_CSTART,
                        ST_SAMPLE, ST_EXEC, ST_WRITE};
  assign FWUPD_EN    = MODE_BOOT;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  a_test_first: assert property (
    (r.st == ST_INIT && nxt.st != ST_INIT)
      |=> r.st == ST_TEST && TEST_GO)
    else $error("self-test not started after init");
  a_usb_io_off: assert property (
    !main_s |-> !IO_EN && !NETVAR_EN)
    else $error("i/o enabled without main power");
  a_run_needs: assert property (
    wd.restart |-> main_s && PROG_LOADED)
    else $error("cycle started without program or power");
  a_cycle_seq: assert property (
    r.st == ST_EXEC && !$past(r.st == ST_EXEC)
      |-> $past(r.st == ST_SAMPLE, 1) && $past(r.st == ST_CSTART, 2))
    else $error("scan cycle out of order");
  a_snap_hold: assert property (
    r.st == ST_EXEC |=> $stable(IN_SNAP))
    else $error("snapshot changed during execution");
  a_err_entry: assert property (
    running && err_any && !FW_START_FAIL |=> MODE_ERR)
    else $error("error not entered");
  a_stat_read: assert property (
    ST_RD && ST_ADDR == STAT_ADDR
      |=> ST_ACK && !ST_NAK && ST_DATA == $past(r.stat))
    else $error("status read wrong");
  a_pwr_bit: assert property (
    $past(RSTN) |-> r.stat[B_NOPWR] == $past(!main_s))
    else $error("power bit wrong");
  a_ovr_bit: assert property (
    wd.overrun |=> ##1 r.stat[B_FWCYC])
    else $error("slow cycle not flagged");
  a_halt_dio: assert property (
    running && main_s && halt_s && !err_any && !FW_START_FAIL
      |=> MODE_DIO && r.stat[B_TERM] == 1'b0 ##1 r.stat[B_TERM])
    else $error("halt did not stop program");
  a_dio_nonet: assert property (
    MODE_DIO |-> !NETVAR_EN)
    else $error("network variables open in direct i/o");
  a_boot_only: assert property (
    MODE_BOOT |-> !IO_EN && !NETVAR_EN && !USB_PROG_EN && FWUPD_EN)
    else $error("bootloader left functions enabled");
  a_boot_start: assert property (
    running && FW_START_FAIL |=> MODE_BOOT)
    else $error("bootloader not entered");
  a_boot_force: assert property (
    r.st == ST_TEST && TEST_DONE && r.boot |=> MODE_BOOT)
    else $error("forced bootloader ignored");
  a_unused_zero: assert property (
    (r.stat & UNUSED_MASK) == 32'h0000_0000)
    else $error("unused status bit set");
  c_full_cycle: cover property (
    r.st == ST_CSTART ##1 r.st == ST_SAMPLE ##[1:20] r.st == ST_WRITE);
  c_halt_dio: cover property (running ##1 MODE_DIO);
  c_err_mode: cover property ($rose(MODE_ERR));
  c_boot_mode: cover property ($rose(MODE_BOOT));
endmodule
`default_nettype wire

// ===== omc_pkg.sv
// Purpose: shared constants and types of the operating mode controller
// Assumes: 125 MHz system clock
// Notes:   status bit positions and the status word address live here
`default_nettype none
package omc_pkg;
  // ---------------------------------------------------------------
  // status word access
  // ---------------------------------------------------------------
  localparam logic [15:0] STAT_ADDR = 16'hf0b4; // holding register
  localparam int          IN_W      = 16;       // input snapshot width
  // ---------------------------------------------------------------
  // status bit positions
  // ---------------------------------------------------------------
  localparam int B_DI = 0, B_DO = 1, B_AI = 2, B_AO = 3;
  localparam int B_ETH = 4, B_USB = 6, B_RS1 = 8, B_RS2 = 9;
  localparam int B_RTC = 11, B_NOPWR = 12, B_FWCYC = 13;
  localparam int B_OS = 15, B_FS = 16, B_FMT = 17, B_NOPAR = 18;
  localparam int B_FWVER = 19, B_FACT = 20, B_ARCH = 21;
  localparam int B_HALT = 22, B_NOPROG = 23, B_TERM = 24;
  localparam int B_RETAIN = 31;
  localparam logic [31:0] UNUSED_MASK = 32'h7e00_44a0; // always zero
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ      = 125000; // system clock rate
  localparam int CYC_MAX_MS   = 100;    // longest operational cycle
  localparam int CYC_LIMIT    = CYC_MAX_MS * CLK_KHZ;
  localparam int CNT_W        = 24;     // cycle timer width
  localparam logic [1:0] SETTLE = 2'h3; // synchroniser settle cycles
  // ---------------------------------------------------------------
  // controller states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [9:0] {
    ST_INIT   = 10'h001, // sample switch and button
    ST_TEST   = 10'h002, // self-test
    ST_IDLE   = 10'h004, // usb only or no program
    ST_CSTART = 10'h008, // cycle start
    ST_SAMPLE = 10'h010, // sample inputs
    ST_EXEC   = 10'h020, // run program
    ST_WRITE  = 10'h040, // update outputs
    ST_DIO    = 10'h080, // direct i/o
    ST_ERR    = 10'h100, // error mode
    ST_BOOT   = 10'h200  // bootloader
  } omc_state_t;
endpackage
`default_nettype wire

// ===== omc_wdog_if.sv
// Purpose: link between controller and cycle timer
// Assumes: single clock domain
// Notes:   restart is a one-cycle pulse at cycle start
`timescale 1ns/1ps
`default_nettype none
interface omc_wdog_if;
  logic run;     // operational cycle in progress
  logic restart; // new cycle begins
  logic overrun; // cycle exceeded its limit
  modport ctrl (output run, output restart, input overrun);
  modport tmr  (input run, input restart, output overrun);
endinterface
`default_nettype wire

// ===== omc_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to the clock
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module omc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1; // metastable stage
    logic [W-1:0] s2; // settled stage
  } omcs_t;
  omcs_t r, nxt;
  // shift one stage per clock
  always_comb begin
    nxt    = r;
    nxt.s1 = d;
    nxt.s2 = r.s1;
  end
  // register with synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end
  assign q = r.s2;
endmodule
`default_nettype wire

// ===== omc_wdog.sv
// Purpose: measures each operational cycle against its limit
// Assumes: restart pulses once per cycle start
// Notes:   overrun stays high until the next restart
`timescale 1ns/1ps
`default_nettype none
module omc_wdog #(
  parameter int LIMIT = omc_pkg::CYC_LIMIT
) (
  input wire logic clk,
  input wire logic rst_n,
  omc_wdog_if.tmr  wd
);
  import omc_pkg::*;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] cnt;  // cycles in current cycle
    logic             over; // limit passed
  } omcw_t;
  omcw_t r, nxt;
  // count while running, flag at the limit
  always_comb begin
    nxt = r;
    if (wd.restart) begin
      nxt = '0;
    end else if (wd.run && !r.over) begin
      if (r.cnt == LAST) begin
        nxt.over = 1'b1;
      end else begin
        nxt.cnt = r.cnt + 1'b1;
      end
    end
  end
  // register with synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end
  assign wd.overrun = r.over;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_over_at_limit: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(r.over) |-> $past(r.cnt) == LAST)
    else $error("overrun not at limit");
endmodule
`default_nettype wire

// ===== omc_far_model.sv
// Purpose: far-side model answering self-test and program passes
// Assumes: one clock, requests are one-cycle pulses
// Notes:   answers program passes late when slow is set, fails test when fail is set
`timescale 1ns/1ps
`default_nettype none
module omc_far_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // commands from the bench
  input  wire logic fail,
  input  wire logic slow,
  // handshake with the controller
  input  wire logic test_go,
  input  wire logic exec_go,
  output logic      test_done,
  output logic      test_fail,
  output logic      exec_done
);
  // ------------------------------------------------------------
  // answer timers
  // ------------------------------------------------------------
  int tc_r; // self-test cycles left, 0 when idle
  int ec_r; // program pass cycles left, 0 when idle
  // counts down, then pulses done for one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {tc_r, ec_r} <= '0;
      {test_done, test_fail, exec_done} <= 3'h0;
    end else begin
      test_done <= test_go ? 1'b0 : (tc_r == 1);
      test_fail <= test_go ? 1'b0 : (tc_r == 1) && fail;
      exec_done <= exec_go ? 1'b0 : (ec_r == 1);
      tc_r <= test_go ? 5 : (tc_r != 0) ? tc_r - 1 : 0;
      ec_r <= exec_go ? (slow ? 60 : 3) : (ec_r != 0) ? ec_r - 1 : 0;
    end
  end
endmodule
`default_nettype wire

// ===== operating_mode_controller_bench.sv
// Purpose: bench for the mode controller and its status word
// Assumes: far-side model answers self-test and program passes
// Notes:   cycle limit shortened to 40 clocks
`timescale 1ns/1ps
`default_nettype none
module operating_mode_controller_bench;
  import omc_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic        mclk = 1'b0, rstn = 1'b0, st_rd = 1'b0;
  logic        halt = 1'b0, btn = 1'b0, mpwr = 1'b1, prog = 1'b1;
  logic        fail = 1'b0, slow = 1'b0;
  logic [15:0] pins = 16'h5a3c, st_addr = 16'h0;
  logic [18:0] f = 19'h0;          // fault inputs
  logic [31:0] msk = 32'hffffffff; // status bits compared
  logic        test_go, test_done, test_fail, exec_go, exec_done, out_upd;
  logic        m_op, m_err, m_dio, m_boot, io_en, nv_en, usb_en, fw_en;
  logic        st_ack, st_nak;
  logic [15:0] snap;
  logic [31:0] st_data;
  int          error_cnt = 0, num_checks = 0;
  // status word expected for each single fault input except the start failure
  localparam logic [31:0] fmap [18] = '{32'h1, 32'h2, 32'h4, 32'h8,
    32'h10, 32'h40, 32'h100, 32'h200, 32'h800, 32'h8_2000, 32'h8000,
    32'h1_0000, 32'h2_0000, 32'h4_0000, 32'h8_0000, 32'h0, 32'h20_0000,
    32'h8000_0000};
  always #4 mclk = ~mclk;
  omc_top #(.CYC_LIMIT_CYCLES(40), .HAS_AO(1'b1)) uut (
    .MCLK(mclk), .RSTN(rstn), .RUN_HALT_PIN(halt), .SVC_BTN_PIN(btn),
    .MAIN_PWR_PIN(mpwr), .IN_PINS(pins), .TEST_GO(test_go),
    .TEST_DONE(test_done), .TEST_FAIL(test_fail), .PROG_LOADED(prog),
    .EXEC_GO(exec_go), .EXEC_DONE(exec_done), .IN_SNAP(snap),
    .OUT_UPDATE(out_upd), .FLT_IO(f[3:0]), .FLT_IF(f[7:4]),
    .FLT_RTC(f[8]), .FLT_FW(f[9]), .FLT_OS(f[10]), .FLT_FS(f[11]),
    .STOR_FMT(f[12]), .NO_PARAMS(f[13]), .FW_MISMATCH(f[14]),
    .FACTORY_RST(f[15]), .ARCH_FLT(f[16]), .RETAIN_BAD(f[17]),
    .FW_START_FAIL(f[18]), .MODE_OPER(m_op), .MODE_ERR(m_err),
    .MODE_DIO(m_dio), .MODE_BOOT(m_boot), .IO_EN(io_en),
    .NETVAR_EN(nv_en), .USB_PROG_EN(usb_en), .FWUPD_EN(fw_en),
    .ST_RD(st_rd), .ST_ADDR(st_addr), .ST_ACK(st_ack), .ST_NAK(st_nak),
    .ST_DATA(st_data));
  omc_far_model far (.clk(mclk), .rst_n(rstn), .fail(fail), .slow(slow),
    .test_go(test_go), .exec_go(exec_go), .test_done(test_done),
    .test_fail(test_fail), .exec_done(exec_done));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // picks the output that a wait looks for
  function automatic logic sel(input int k);
    case (k)
      0: return test_go;
      1: return m_op;
      2: return exec_go;
      3: return out_upd;
      4: return m_dio;
      5: return m_err;
      default: return m_boot;
    endcase
  endfunction
  // bounded wait; running out ends the run
  task automatic wt(input int k);
    for (int i = 0; i < 300 && !sel(k); i++) @(negedge mclk);
    if (sel(k) !== 1'b1) begin
      chk(32'h0, 32'h1);
      report_and_stop();
    end
  endtask
  // power-up with the given switch, button, supply and program state
  task automatic start(input logic h, b, p, g);
    @(negedge mclk);
    {halt, btn, mpwr, prog, f, slow, rstn} = {h, b, p, g, 20'h0, 1'b0};
    step(6);
    rstn = 1'b1;
  endtask
  // one status read, answer checked in the cycle it stands
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    {st_rd, st_addr} = {1'b1, a};
    @(negedge mclk);
    st_rd = 1'b0;
    chk({st_ack, st_nak}, (a == STAT_ADDR) ? 2'h2 : 2'h1);
    chk(st_data & msk, e);
    @(negedge mclk); // idle cycle before the next request
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    start(1'b0, 1'b0, 1'b1, 1'b1);
    chk({m_op, m_err, m_dio, m_boot, io_en}, 5'h0);
    wt(0);
    chk(m_op, 1'b0);
    wt(1);
    chk({io_en, nv_en}, 2'h3);
    wt(2);
    chk(snap, 16'h5a3c);
    pins = 16'h0ff0;
    step(1);
    chk(snap, 16'h5a3c);
    wt(3);
    step(3);
    chk(exec_go, 1'b1);
    chk(snap, 16'h0ff0);
    f[13:12] = 2'h3;
    step(3);
    rd(STAT_ADDR, 32'h6_0000);
    rd(16'hf0b5, 32'h6_0000);
    chk(m_op, 1'b1);
    halt = 1'b1;
    wt(4);
    chk({io_en, nv_en}, 2'h2);
    step(2);
    rd(STAT_ADDR, 32'h146_0000);
    // error mode, then each fault input alone except the start failure
    start(1'b0, 1'b0, 1'b1, 1'b1);
    wt(1);
    f[0] = 1'b1;
    wt(5);
    msk = ~32'h100_0000;
    for (int i = 0; i < 18; i++) begin
      f = 19'h1 << i;
      step(3);
      rd(STAT_ADDR, fmap[i]);
    end
    // firmware that cannot start, then forced bootloader
    start(1'b0, 1'b0, 1'b1, 1'b1);
    wt(1);
    f[18] = 1'b1;
    wt(6);
    chk({fw_en, io_en, nv_en}, 3'h4);
    start(1'b0, 1'b1, 1'b1, 1'b1); // button held at power-up
    wt(0);
    wt(6);
    chk({m_op, fw_en, io_en}, 3'h2);
    // usb power only, then no program after factory restore
    msk = 32'hffffffff;
    start(1'b0, 1'b0, 1'b0, 1'b1);
    wt(0);
    step(10);
    chk({m_op, io_en, usb_en}, 3'h1);
    rd(STAT_ADDR, 32'h1000);
    start(1'b0, 1'b0, 1'b1, 1'b0);
    f[15] = 1'b1;
    wt(0);
    step(10);
    chk(m_op, 1'b0);
    rd(STAT_ADDR, 32'h90_0000);
    // halt latched at power-up, then run; failed self-test
    start(1'b1, 1'b0, 1'b1, 1'b1);
    wt(4);
    halt = 1'b0;
    wt(1);
    fail = 1'b1;
    start(1'b0, 1'b0, 1'b1, 1'b1);
    wt(5);
    fail = 1'b0;
    // program pass longer than the cycle limit
    start(1'b0, 1'b0, 1'b1, 1'b1);
    slow = 1'b1;
    wt(1);
    wt(5);
    msk = ~32'h100_0000;
    rd(STAT_ADDR, 32'h2000);
    report_and_stop();
  end
endmodule
`default_nettype wire
